// >>> hw/led_sink_ctrl.sv
// Behaviour
// - with path select low, shifted serial bits load the six-bit gain code.
// - channel current scales linearly with the latched six-bit gain code.
// - applied gain code holds until a new gain code is latched.
// - gain code powers up as 011111, about half base current.
// - with path select high, serial bits shift into sixteen channel bits.
// - a latched one turns its channel on, a zero turns it off.
// - latch passes shift contents while strobe high, holds while low.
// - serial out changes on falling clock edge if edge select high, else rising.
// - fault line pulled low while over-temperature indication asserts.
// - thermal fault releases only when cooled below low threshold or reset.
// - fault line is the or of thermal fault and open-led fault.
// - output enable high turns all outputs off and stops open detection.
// - open-led fault when any switched-on output shows low voltage.
// - open-led fault valid only after a settle time after switch-on.
//
// file holds the whole sink controller: pin sampling, shift paths, latches,
// fault logic and an apb register slave. all non-apb pins come from outside pclk and
// are synchronised; the serial clock is sampled, so it must run well below pclk.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ns
module led_sink_ctrl #(
  parameter int CHANNELS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic path_select,
  input wire logic latch_strobe,
  input wire logic out_edge_select,
  input wire logic out_enable_n,
  input wire logic temp_above_high,
  input wire logic temp_below_low,
  input wire logic [CHANNELS-1:0] low_voltage,
  output logic [CHANNELS-1:0] sink_channel,
  output logic [led_sink_pkg::GAIN_W-1:0] gain_code,
  output logic serial_out,
  output logic alarm_out,
  output logic alarm_oe
);
  import led_sink_pkg::*;

  localparam int SYNC_W = CHANNELS + 8;

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic sclk_d_reg;
  logic [GAIN_W-1:0] gain_shift_reg;
  logic [CHANNELS-1:0] chan_shift_reg;
  logic [GAIN_W-1:0] gain_reg;
  logic [CHANNELS-1:0] chan_latch_reg;
  logic [CHANNELS-1:0] sink_reg;
  logic serial_out_reg;
  logic thermal_reg;
  logic open_reg;
  logic alarm_oe_reg;
  logic [3:0] settle_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  apb_state_e apb_state_reg;

  // synchronised pin views, only the second stage is read
  wire sclk_s = sync2_reg[SYNC_W-1];
  wire sdi_s = sync2_reg[SYNC_W-2];
  wire sel_s = sync2_reg[SYNC_W-3];
  wire lat_s = sync2_reg[SYNC_W-4];
  wire edge_s = sync2_reg[SYNC_W-5];
  wire oe_n_s = sync2_reg[SYNC_W-6];
  wire hot_s = sync2_reg[SYNC_W-7];
  wire cool_s = sync2_reg[SYNC_W-8];
  wire [CHANNELS-1:0] lowv_s = sync2_reg[CHANNELS-1:0];

  // serial clock edges found by sampling
  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;

  // shift paths, msb first so the first bit ends on top
  wire [GAIN_W-1:0] gain_shift_next = {gain_shift_reg[GAIN_W-2:0], sdi_s};
  wire [CHANNELS-1:0] chan_shift_next = {chan_shift_reg[CHANNELS-2:0], sdi_s};
  wire gain_step = sclk_rise & ~sel_s;
  wire chan_step = sclk_rise & sel_s;

  // last stage of the active path feeds the next device in a chain
  wire tail_now = sel_s ? chan_shift_reg[CHANNELS-1] : gain_shift_reg[GAIN_W-1];
  wire tail_after = sel_s ? chan_shift_next[CHANNELS-1] : gain_shift_next[GAIN_W-1];

  // transparent latches, one per path, updated only for the selected path
  wire gain_open = lat_s & ~sel_s;
  wire chan_open = lat_s & sel_s;

  // sink outputs gated by the enable pin
  wire [CHANNELS-1:0] sink_next = oe_n_s ? '0 : chan_latch_reg;

  // open detection waits for the switched-on set to settle
  wire settle_restart = (sink_next != sink_reg);
  wire settled = (settle_reg == SETTLE_DONE);
  wire [3:0] settle_next = settle_restart ? 4'h0 : (settled ? settle_reg : settle_reg + 4'h1);
  wire detect_en = ctrl_reg[CTRL_DETECT_BIT] & ~oe_n_s;
  wire open_next = detect_en & settled & (|(sink_reg & lowv_s));

  // thermal flag: set wins over the release so a new hot event is never lost
  wire thermal_next = hot_s | (thermal_reg & ~cool_s);

  // apb decode
  wire apb_access = psel & penable;
  // the write lands at the edge where the master samples pready high
  wire apb_take = apb_access & (apb_state_reg == APB_DONE);
  wire hit_ctrl = (paddr == CTRL_OFFSET);
  wire hit_status = (paddr == STATUS_OFFSET);
  wire hit_chan = (paddr == CHAN_OFFSET);
  wire hit_lowv = (paddr == LOWV_OFFSET);
  wire hit_any = hit_ctrl | hit_status | hit_chan | hit_lowv;
  wire write_ok = apb_take & pwrite & hit_ctrl;
  wire bad_access = ~hit_any | (pwrite & ~hit_ctrl);
  wire [31:0] status_word = {16'h0000, 2'b00, gain_reg, 4'h0, oe_n_s, sel_s, open_reg,
                             thermal_reg};
  wire [31:0] read_word = hit_ctrl ? ctrl_reg :
                          hit_status ? status_word :
                          hit_chan ? 32'(chan_latch_reg) :
                          hit_lowv ? 32'(lowv_s) : 32'h0000_0000;

  // two-flop pin synchroniser and serial clock history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sclk_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {serial_clock, serial_in, path_select, latch_strobe, out_edge_select,
                    out_enable_n, temp_above_high, temp_below_low, low_voltage};
      sync2_reg <= sync1_reg;
      sclk_d_reg <= sclk_s;
    end
  end

  // shift registers step on sampled rising serial clock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_shift_reg <= '0;
      chan_shift_reg <= '0;
    end else begin
      if (gain_step) gain_shift_reg <= gain_shift_next;
      if (chan_step) chan_shift_reg <= chan_shift_next;
    end
  end

  // latches; the gain power-up value stands until a gain latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_reg <= GAIN_RESET;
      chan_latch_reg <= CHAN_RESET;
    end else begin
      if (gain_open) gain_reg <= gain_shift_reg;
      if (chan_open) chan_latch_reg <= chan_shift_reg;
    end
  end

  // serial out: rising mode shows the post-shift tail, falling mode half a clock later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_reg <= 1'b0;
    end else if (edge_s && sclk_fall) begin
      serial_out_reg <= tail_now;
    end else if (!edge_s && sclk_rise) begin
      serial_out_reg <= tail_after;
    end
  end

  // sink drive, fault flags and the open-drain alarm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_reg <= '0;
      settle_reg <= 4'h0;
      open_reg <= 1'b0;
      thermal_reg <= 1'b0;
      alarm_oe_reg <= 1'b0;
    end else begin
      sink_reg <= sink_next;
      settle_reg <= settle_next;
      open_reg <= open_next;
      thermal_reg <= thermal_next;
      alarm_oe_reg <= thermal_reg | open_reg;
    end
  end

  // apb slave: two wait states so every answer comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_reg <= APB_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      ctrl_reg <= CTRL_RESET;
    end else begin
      case (apb_state_reg)
        APB_IDLE: begin
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
          if (apb_access) apb_state_reg <= APB_WAIT;
        end
        APB_WAIT: begin
          pready_reg <= 1'b1;
          pslverr_reg <= bad_access;
          prdata_reg <= pwrite ? 32'h0000_0000 : read_word;
          apb_state_reg <= APB_DONE;
        end
        APB_DONE: begin
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
          apb_state_reg <= APB_IDLE;
        end
        default: apb_state_reg <= APB_IDLE;
      endcase
      if (write_ok) ctrl_reg <= pwdata;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign sink_channel = sink_reg;
  // gain code scales every channel's current linearly in the analogue stage
  assign gain_code = gain_reg;
  assign serial_out = serial_out_reg;
  assign alarm_out = 1'b0;
  assign alarm_oe = alarm_oe_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_gain_clock;
    sclk_rise && !sel_s;
  endsequence
  sequence s_chan_clock;
    sclk_rise && sel_s;
  endsequence
  sequence s_chan_latch_held;
    chan_open ##1 chan_open;
  endsequence

  a_gain_shift_in: assert property (s_gain_clock |=>
    gain_shift_reg == {$past(gain_shift_reg[GAIN_W-2:0]), $past(sdi_s)})
    else $error("gain shift path did not take the serial bit");
  a_chan_shift_in: assert property (s_chan_clock |=>
    chan_shift_reg == {$past(chan_shift_reg[CHANNELS-2:0]), $past(sdi_s)})
    else $error("channel shift path did not take the serial bit");
  a_gain_code_hold: assert property (!gain_open |=> $stable(gain_reg))
    else $error("gain code changed without a gain latch");
  a_chan_latch_pass: assert property (s_chan_latch_held |->
    chan_latch_reg == $past(chan_shift_reg))
    else $error("open channel latch did not follow the shift path");
  a_sink_off_enable: assert property (oe_n_s ##1 oe_n_s |-> sink_reg == '0)
    else $error("outputs on while enable is high");
  a_sink_follows_latch: assert property (!oe_n_s |=> sink_reg == $past(chan_latch_reg))
    else $error("sink outputs do not match latched bits");
  a_so_falling_edge: assert property (edge_s && sclk_fall |=>
    serial_out_reg == $past(tail_now))
    else $error("serial out missed the falling edge update");
  a_thermal_sets: assert property (hot_s |=> thermal_reg ##1 alarm_oe_reg)
    else $error("over-temperature did not pull the fault line");
  a_thermal_hold: assert property (thermal_reg && !cool_s |=> thermal_reg)
    else $error("thermal fault released before cooling");
  a_alarm_is_or: assert property (##1 alarm_oe_reg == $past(thermal_reg | open_reg))
    else $error("fault line is not the or of both faults");
  a_open_needs_settle: assert property ($rose(open_reg) |->
    $past(settled) && $past(|(sink_reg & lowv_s)) && !$past(oe_n_s))
    else $error("open fault raised before settling or without cause");
  a_gain_powerup: assert property ($rose(presetn) |-> gain_reg == GAIN_RESET)
    else $error("gain code not at power-up value");
endmodule

// >>> hw/led_sink_pkg.sv
// constants for the serial-in latched led sink controller
// assumes a 10 MHz pclk and an apb master on the register side
package led_sink_pkg;
  localparam int CHAN_W = 16;
  localparam int GAIN_W = 6;
  localparam int CLK_PERIOD_NS = 100;
  // open-led detection settles this long after a channel is switched on
  localparam int OPEN_DELAY_NS = 200;
  localparam int OPEN_DELAY_CYC_RAW = (OPEN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OPEN_DELAY_CYC = (OPEN_DELAY_CYC_RAW < 1) ? 1 : OPEN_DELAY_CYC_RAW;
  localparam logic [3:0] SETTLE_DONE = 4'(OPEN_DELAY_CYC);
  // gain code applied at power-up, about half of the base current
  localparam logic [5:0] GAIN_RESET = 6'h1F;
  localparam logic [15:0] CHAN_RESET = 16'h0000;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CHAN_OFFSET = 8'h08;
  localparam logic [7:0] LOWV_OFFSET = 8'h0C;
  // ctrl fields
  localparam int CTRL_DETECT_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // status fields
  localparam int STAT_THERMAL_BIT = 0;
  localparam int STAT_OPEN_BIT = 1;
  localparam int STAT_SELECT_BIT = 2;
  localparam int STAT_ENABLE_N_BIT = 3;
  localparam int STAT_GAIN_LSB = 8;
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_WAIT = 2'b01,
    APB_DONE = 2'b10
  } apb_state_e;
endpackage

// >>> testbench/display_ctl_model.sv
// display controller model: drives the serial link pins of the led sink
// assumes pclk at 100 ns; the link clock runs 8 pclk (800 ns) and rests low between frames
`timescale 1ns/1ns
module display_ctl_model (
  input wire logic pclk,
  input wire logic serial_out,
  output logic serial_clock,
  output logic serial_in,
  output logic path_select,
  output logic latch_strobe
);
  logic so_hi;
  initial begin
    serial_clock = 1'b0;
    serial_in = 1'b0;
    path_select = 1'b0;
    latch_strobe = 1'b0;
    so_hi = 1'b0;
  end
  // send n bits of v, top bit first; data held through the whole high phase
  task automatic send(input logic sel, input int n, input logic [31:0] v);
    path_select <= sel;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in <= v[i];
      repeat (3) @(posedge pclk);
      serial_clock <= 1'b1;
      repeat (4) @(posedge pclk);
      serial_clock <= 1'b0;
      @(posedge pclk);
      so_hi = serial_out; // cascade value just after the fall, before it can react
    end
    serial_in <= ~v[0]; // hold over: the line no longer carries the last bit
  endtask
  // pulse the strobe; keep leaves the latch transparent for a walk
  task automatic strobe(input logic keep);
    latch_strobe <= 1'b1;
    if (!keep) begin
      repeat (4) @(posedge pclk);
      latch_strobe <= 1'b0;
    end
    @(posedge pclk);
  endtask
endmodule

// >>> testbench/led_sink_shift_latch_alarm_bench.sv
// self-checking bench for the led sink controller
// assumes the apb slave answers after two wait states and pins lag 2-3 pclk
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
  check_count++; \
  if ((got) !== (ex)) begin \
    err_total++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
  end \
end
module led_sink_shift_latch_alarm_bench;
  import led_sink_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic serial_clock, serial_in, path_select, latch_strobe, out_edge_select, out_enable_n;
  logic temp_above_high, temp_below_low, serial_out, alarm_out, alarm_oe;
  logic [15:0] low_voltage, sink_channel;
  logic [5:0] gain_code;
  int err_total = 0;
  int check_count = 0;
  led_sink_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_clock(serial_clock), .serial_in(serial_in),
    .path_select(path_select), .latch_strobe(latch_strobe), .out_edge_select(out_edge_select),
    .out_enable_n(out_enable_n), .temp_above_high(temp_above_high),
    .temp_below_low(temp_below_low), .low_voltage(low_voltage), .sink_channel(sink_channel),
    .gain_code(gain_code), .serial_out(serial_out), .alarm_out(alarm_out), .alarm_oe(alarm_oe));
  display_ctl_model HOST (.pclk(pclk), .serial_out(serial_out), .serial_clock(serial_clock),
    .serial_in(serial_in), .path_select(path_select), .latch_strobe(latch_strobe));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      err_total++;
      $display("[FAIL] apb pready expected 1 seen %b", pready);
      wrap_up();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {out_edge_select, out_enable_n, temp_above_high, temp_below_low, low_voltage} = '0;
    idle(4);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("gain reset", GAIN_RESET, gain_code)
    `CHK("alarm idle", 1'b0, alarm_oe)
    apb(0, CTRL_OFFSET, 32'h0);
    `CHK("ctrl reset", CTRL_RESET, rd)
    $display("test reset done");
    HOST.send(0, 6, 32'h25);
    `CHK("gain before latch", GAIN_RESET, gain_code)
    HOST.strobe(0);
    idle(4);
    `CHK("gain latched", 6'h25, gain_code)
    $display("test gain done");
    HOST.send(1, 16, 32'hA5C3);
    `CHK("rise edge out", 1'b1, HOST.so_hi)
    `CHK("sink before latch", 16'h0000, sink_channel)
    HOST.strobe(0);
    idle(4);
    `CHK("sink latched", 16'hA5C3, sink_channel)
    `CHK("gain kept", 6'h25, gain_code)
    apb(0, CHAN_OFFSET, 32'h0);
    `CHK("chan reg", 32'h0000A5C3, rd)
    out_edge_select <= 1'b1;
    idle(2);
    HOST.send(1, 1, 32'h0);
    `CHK("fall edge hold", 1'b1, HOST.so_hi)
    idle(4);
    `CHK("fall edge out", 1'b0, serial_out)
    `CHK("sink held", 16'hA5C3, sink_channel)
    out_enable_n <= 1'b1;
    idle(5);
    `CHK("sink disabled", 16'h0000, sink_channel)
    out_enable_n <= 1'b0;
    $display("test channel done");
    low_voltage <= 16'h0004;
    idle(8);
    `CHK("off channel low", 1'b0, alarm_oe)
    low_voltage <= 16'h0001;
    idle(6);
    `CHK("open alarm", 1'b1, alarm_oe)
    out_enable_n <= 1'b1;
    idle(6);
    `CHK("open cleared", 1'b0, alarm_oe)
    out_enable_n <= 1'b0;
    apb(1, CTRL_OFFSET, 32'h0);
    idle(6);
    `CHK("detect off", 1'b0, alarm_oe)
    apb(1, CTRL_OFFSET, 32'h1);
    // walk a single one through a transparent latch to find channel 3
    low_voltage <= 16'h0008;
    apb(0, LOWV_OFFSET, 32'h0);
    `CHK("lowv reg", 32'h0000_0008, rd)
    HOST.send(1, 16, 32'h0);
    HOST.strobe(1);
    for (int k = 0; k < 6; k++) begin
      HOST.send(1, 1, {31'h0, k == 0});
      idle(6);
      `CHK("walk alarm", k == 3, alarm_oe)
    end
    HOST.strobe(0);
    // chain check: all ones shifted and latched, then outputs enabled
    out_enable_n <= 1'b1;
    HOST.send(1, 32, 32'hFFFF_FFFF);
    HOST.strobe(0);
    out_enable_n <= 1'b0;
    idle(8);
    `CHK("all on", 16'hFFFF, sink_channel)
    `CHK("chain alarm", 1'b1, alarm_oe)
    low_voltage <= 16'h0000;
    $display("test open done");
    temp_above_high <= 1'b1;
    idle(6);
    `CHK("hot alarm", 1'b1, alarm_oe)
    out_enable_n <= 1'b1;
    temp_above_high <= 1'b0;
    idle(6);
    `CHK("hot held", 1'b1, alarm_oe)
    `CHK("drain data", 1'b0, alarm_out)
    apb(0, STATUS_OFFSET, 32'h0);
    `CHK("status hot", 1'b1, rd[STAT_THERMAL_BIT])
    `CHK("status enable", 1'b1, rd[STAT_ENABLE_N_BIT])
    `CHK("status select", 1'b1, rd[STAT_SELECT_BIT])
    `CHK("status gain", 6'h25, rd[STAT_GAIN_LSB +: GAIN_W])
    temp_below_low <= 1'b1;
    idle(6);
    `CHK("cooled", 1'b0, alarm_oe)
    temp_below_low <= 1'b0;
    $display("test thermal done");
    apb(1, STATUS_OFFSET, 32'hFFFFFFFF);
    `CHK("ro write", 1'b1, err)
    apb(0, 8'h10, 32'h0);
    `CHK("unmapped", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    $display("test apb done");
    wrap_up();
  end
endmodule
